// ---- rtl/slb_pkg.sv ----
package slb_pkg;

  // Clock and link bit timing; one bit time at 10 Mbit/s
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BIT_TIME_NS   = 100;
  localparam int BIT_CYC       = (BIT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int HALF_CYC      = BIT_CYC / 2;
  localparam int CW            = 5;
  localparam logic [CW-1:0] BIT_LAST  = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);

  // Packet shapes: data is 1,1,8 data bits LSB first,0; ack is 1,0
  localparam int DATA_PKT_BITS = 11;
  localparam int ACK_PKT_BITS  = 2;
  localparam logic [3:0] DATA_LAST = 4'(DATA_PKT_BITS - 1);
  localparam logic [3:0] ACK_LAST  = 4'(ACK_PKT_BITS - 1);
  localparam logic [3:0] RX_SAMP_LAST = 4'h8;
  localparam logic [10:0] ACK_PATTERN = 11'h001;

  // Register select codes
  localparam logic [1:0] SEL_RX_DATA = 2'h0;
  localparam logic [1:0] SEL_TX_DATA = 2'h1;
  localparam logic [1:0] SEL_RX_STAT = 2'h2;
  localparam logic [1:0] SEL_TX_STAT = 2'h3;

  // Status register field positions
  localparam int FLAG_BIT = 0;
  localparam int IE_BIT   = 1;

  // Values after reset
  localparam logic       RX_VALID_RST = 1'h0;
  localparam logic       TX_READY_RST = 1'h1;
  localparam logic       IE_RST       = 1'h0;
  localparam logic [7:0] BYTE_RST     = 8'h00;

  // Access latched at chip select fall
  typedef struct packed {
    logic [1:0] sel;
    logic       rd;
  } slb_acc_t;

  // Event reported by the link receiver
  typedef struct packed {
    logic       data_vld;
    logic       ack_vld;
    logic [7:0] dat;
  } slb_rx_evt_t;

endpackage

// ---- rtl/slb_link_tx.sv ----
`timescale 1ns/100ps
module slb_link_tx (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       send_data_i,
  input  wire logic [7:0] data_byte_i,
  input  wire logic       send_ack_i,
  output logic            serial_o,
  output logic            data_done_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_SEND} slb_tx_st_t;

  slb_tx_st_t        st_r,    st_nxt;
  logic [slb_pkg::CW-1:0] cnt_r, cnt_nxt;
  logic [10:0]       shf_r,   shf_nxt;
  logic [3:0]        nbit_r,  nbit_nxt;
  logic              isd_r,   isd_nxt;
  logic              pd_r,    pd_nxt;
  logic              pa_r,    pa_nxt;
  logic [7:0]        byte_r,  byte_nxt;
  logic              ser_r,   ser_nxt;
  logic              done_r,  done_nxt;

  // Packet scheduler; an ack always goes before a waiting data packet
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    shf_nxt  = shf_r;
    nbit_nxt = nbit_r;
    isd_nxt  = isd_r;
    pd_nxt   = pd_r;
    pa_nxt   = pa_r;
    byte_nxt = byte_r;
    ser_nxt  = ser_r;
    done_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (pa_r || pd_r) begin
          st_nxt  = ST_GAP;             // One bit of lead-in [RL16]
          cnt_nxt = slb_pkg::BIT_LAST;
        end
      end
      ST_GAP: begin
        if (cnt_r == '0) begin
          if (pa_r) begin               // Ack jumps the queue [RL17]
            shf_nxt  = slb_pkg::ACK_PATTERN;
            nbit_nxt = slb_pkg::ACK_LAST;
            isd_nxt  = 1'b0;
            pa_nxt   = 1'b0;
          end else begin
            shf_nxt  = {1'b0, byte_r, 2'h3}; // Data packet [RL9]
            nbit_nxt = slb_pkg::DATA_LAST;
            isd_nxt  = 1'b1;
            pd_nxt   = 1'b0;
          end
          ser_nxt = 1'b1;
          cnt_nxt = slb_pkg::BIT_LAST;
          st_nxt  = ST_SEND;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_SEND: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (nbit_r == '0) begin
          ser_nxt  = 1'b0;
          done_nxt = isd_r;
          st_nxt   = ST_IDLE;
        end else begin
          shf_nxt  = {1'b0, shf_r[10:1]};
          ser_nxt  = shf_r[1];
          nbit_nxt = nbit_r - 1'b1;
          cnt_nxt  = slb_pkg::BIT_LAST;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    // A request in the cycle its pending bit clears is kept
    if (send_ack_i) pa_nxt = 1'b1;
    if (send_data_i) begin
      pd_nxt   = 1'b1;
      byte_nxt = data_byte_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r   <= ST_IDLE;
      cnt_r  <= '0;
      shf_r  <= '0;
      nbit_r <= '0;
      isd_r  <= 1'b0;
      pd_r   <= 1'b0;
      pa_r   <= 1'b0;
      byte_r <= slb_pkg::BYTE_RST;
      ser_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      shf_r  <= shf_nxt;
      nbit_r <= nbit_nxt;
      isd_r  <= isd_nxt;
      pd_r   <= pd_nxt;
      pa_r   <= pa_nxt;
      byte_r <= byte_nxt;
      ser_r  <= ser_nxt;
      done_r <= done_nxt;
    end
  end

  assign serial_o    = ser_r;
  assign data_done_o = done_r;

endmodule

// ---- rtl/slb_link_rx.sv ----
`timescale 1ns/100ps
module slb_link_rx (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          serial_i,
  output slb_pkg::slb_rx_evt_t evt_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_FLAG, ST_DATA, ST_ACKEND
  } slb_rx_st_t;

  slb_rx_st_t        st_r,   st_nxt;
  logic [slb_pkg::CW-1:0] cnt_r, cnt_nxt;
  logic [3:0]        nbit_r, nbit_nxt;
  logic [8:0]        shf_r,  shf_nxt;
  slb_pkg::slb_rx_evt_t evt_r, evt_nxt;

  // Samples each bit at its centre; the second bit tells data from ack
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    nbit_nxt = nbit_r;
    shf_nxt  = shf_r;
    evt_nxt  = '{data_vld: 1'b0, ack_vld: 1'b0, dat: evt_r.dat};
    case (st_r)
      ST_IDLE: begin
        if (serial_i) begin
          st_nxt  = ST_START;
          cnt_nxt = slb_pkg::HALF_LAST;
        end
      end
      ST_START: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (serial_i) begin
          st_nxt  = ST_FLAG;
          cnt_nxt = slb_pkg::BIT_LAST;
        end else begin
          st_nxt = ST_IDLE;          // Glitch, not a start bit
        end
      end
      ST_FLAG: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (serial_i) begin
          st_nxt   = ST_DATA;
          nbit_nxt = slb_pkg::RX_SAMP_LAST;
          cnt_nxt  = slb_pkg::BIT_LAST;
        end else begin
          st_nxt  = ST_ACKEND;
          cnt_nxt = slb_pkg::HALF_LAST;
        end
      end
      ST_DATA: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else begin
          shf_nxt = {serial_i, shf_r[8:1]};
          cnt_nxt = slb_pkg::BIT_LAST;
          if (nbit_r == '0) begin
            evt_nxt.data_vld = 1'b1;  // Whole data packet in [RL1]
            evt_nxt.dat      = shf_nxt[7:0];
            st_nxt           = ST_IDLE;
          end else begin
            nbit_nxt = nbit_r - 1'b1;
          end
        end
      end
      ST_ACKEND: begin
        // Report only once the ack packet has ended [RL18]
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else begin
          evt_nxt.ack_vld = 1'b1;
          st_nxt          = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r   <= ST_IDLE;
      cnt_r  <= '0;
      nbit_r <= '0;
      shf_r  <= '0;
      evt_r  <= '0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      nbit_r <= nbit_nxt;
      shf_r  <= shf_nxt;
      evt_r  <= evt_nxt;
    end
  end

  assign evt_o = evt_r;

endmodule

// ---- rtl/slb_host_port.sv ----
// Overview of operation
// RL1 - Receive-valid sets when a complete data packet has arrived.
// RL2 - Receive-valid clears only on a receive data read or reset.
// RL3 - Reading receive data sends an acknowledge packet on the link.
// RL4 - Receive interrupt equals receive enable AND receive-valid.
// RL5 - Receive interrupt drops on a receive data read and at reset.
// RL6 - Each enable bit is written by the host and reads back as written.
// RL7 - Host writes the flag bit and bits 2 to 7 as zero.
// RL8 - Output-ready is high when empty, set by reset, cleared by write.
// RL9 - Writing transmit data starts a data packet on the link.
// RL10 - Output-ready returns only after the byte is sent and acked.
// RL11 - Transmit interrupt equals transmit enable AND output-ready.
// RL12 - Transmit interrupt drops on a transmit data write and at reset.
// RL13 - Host writes transmit data only while output-ready is high.
// RL14 - Transmit data register is write-only; reads return no content.
// RL15 - Host services data by interrupt or by polling the flags.
// RL16 - Data packet starts 0.8 to 2.5 bits after deselect, plus 2.
// RL17 - Ack queued behind traffic may start up to 11 bits later.
// RL18 - Transmit interrupt within 3.3 bits of ack start, after both end.
// RL19 - Transmit interrupt within 13 bits of the data packet start.
// RL20 - Link delays count in bit times of nominally 100 ns.
// RL21 - Select lines plus direction pick one of four registers.
// RL22 - Select and direction latch at select fall, data at select rise.
// RL23 - Receive data holds only the last data byte; writes ignored.
// RL24 - Flag at bit 0, enable at bit 1, bits 2 to 7 read zero.
`timescale 1ns/100ps
module slb_host_port (
  input  wire logic       CLK_I,
  input  wire logic       RESETN_I,
  input  wire logic       CHIP_SELECT_N_I,
  input  wire logic       READ_NOT_WRITE_I,
  input  wire logic [1:0] REG_SELECT_I,
  input  wire logic [7:0] HOST_DATA_BUS_I,
  output logic      [7:0] HOST_DATA_BUS_O,
  output logic            HOST_DATA_BUS_OE_O,
  input  wire logic       SERIAL_IN_I,
  output logic            SERIAL_OUT_O,
  output logic            RX_IRQ_OUT_O,
  output logic            TX_IRQ_OUT_O
);

  // Bus front end state
  logic                 cs_n_prev_r, cs_n_prev_nxt;
  logic                 active_r,    active_nxt;
  slb_pkg::slb_acc_t    acc_r,       acc_nxt;
  logic [7:0]           dout_r,      dout_nxt;
  logic                 doe_r,       doe_nxt;

  // Receive side state
  logic                 rx_valid_r,  rx_valid_nxt;
  logic [7:0]           rx_byte_r,   rx_byte_nxt;
  logic                 rx_ie_r,     rx_ie_nxt;
  logic                 rx_irq_r,    rx_irq_nxt;
  logic                 ack_req_r,   ack_req_nxt;

  // Transmit side state
  logic                 tx_ready_r,  tx_ready_nxt;
  logic [7:0]           tx_byte_r,   tx_byte_nxt;
  logic                 tx_ie_r,     tx_ie_nxt;
  logic                 tx_irq_r,    tx_irq_nxt;
  logic                 send_r,      send_nxt;
  logic                 sent_r,      sent_nxt;
  logic                 acked_r,     acked_nxt;

  // Strobes decoded from the chip select edges
  logic                 cs_fall;
  logic                 cs_rise;
  logic                 rd_rx_fall;
  logic                 wr_tx_fall;
  logic                 wr_commit;
  logic                 rd_commit;

  // Link side wires
  slb_pkg::slb_rx_evt_t rx_evt;
  logic                 data_done;

  // Read data for a given select code
  function automatic logic [7:0] read_mux(input logic [1:0] sel);
    logic [7:0] val;
    val = 8'h00;
    case (sel)
      slb_pkg::SEL_RX_DATA: val = rx_byte_r;
      slb_pkg::SEL_RX_STAT: begin
        val[slb_pkg::FLAG_BIT] = rx_valid_r;  // [RL24]
        val[slb_pkg::IE_BIT]   = rx_ie_r;     // [RL6]
      end
      slb_pkg::SEL_TX_STAT: begin
        val[slb_pkg::FLAG_BIT] = tx_ready_r;  // [RL24]
        val[slb_pkg::IE_BIT]   = tx_ie_r;     // [RL6]
      end
      // Write-only data port and invalid code return zero [RL14]
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  // Edge strobes; select and direction only count while latched
  assign cs_fall    = !CHIP_SELECT_N_I && cs_n_prev_r;
  assign cs_rise    = CHIP_SELECT_N_I && !cs_n_prev_r && active_r;
  assign rd_rx_fall = cs_fall && READ_NOT_WRITE_I &&
                      (REG_SELECT_I == slb_pkg::SEL_RX_DATA); // [RL21]
  assign wr_tx_fall = cs_fall && !READ_NOT_WRITE_I &&
                      (REG_SELECT_I == slb_pkg::SEL_TX_DATA); // [RL21]
  assign wr_commit  = cs_rise && !acc_r.rd;
  assign rd_commit  = cs_rise && acc_r.rd;

  // Bus front end: latch access at select fall, drive read data
  always_comb begin
    cs_n_prev_nxt = CHIP_SELECT_N_I;
    active_nxt    = active_r;
    acc_nxt       = acc_r;
    dout_nxt      = dout_r;
    doe_nxt       = doe_r;
    if (cs_fall) begin
      active_nxt = 1'b1;
      acc_nxt    = '{sel: REG_SELECT_I, rd: READ_NOT_WRITE_I}; // [RL22]
      doe_nxt    = READ_NOT_WRITE_I;
      dout_nxt   = read_mux(REG_SELECT_I);                   // [RL21]
    end else if (cs_rise) begin
      active_nxt = 1'b0;
      doe_nxt    = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cs_n_prev_r <= 1'b1;
      active_r    <= 1'b0;
      acc_r       <= '0;
      dout_r      <= 8'h00;
      doe_r       <= 1'b0;
    end else begin
      cs_n_prev_r <= cs_n_prev_nxt;
      active_r    <= active_nxt;
      acc_r       <= acc_nxt;
      dout_r      <= dout_nxt;
      doe_r       <= doe_nxt;
    end
  end

  // Receive side; a new packet in the clearing cycle wins over the read
  always_comb begin
    rx_valid_nxt = rx_valid_r;
    rx_byte_nxt  = rx_byte_r;
    rx_ie_nxt    = rx_ie_r;
    ack_req_nxt  = 1'b0;
    if (rd_rx_fall) begin
      rx_valid_nxt = 1'b0;                  // Only a read or reset clears it [RL2]
    end
    if (rx_evt.data_vld) begin
      rx_valid_nxt = 1'b1;                  // [RL1]
      rx_byte_nxt  = rx_evt.dat;            // Acks never land here [RL23]
    end
    // Ack leaves once the host lets go of the bus [RL3]
    if (rd_commit && (acc_r.sel == slb_pkg::SEL_RX_DATA)) begin
      ack_req_nxt = 1'b1;
    end
    // Only the enable bit is writable; flag and upper bits ignored [RL7]
    if (wr_commit && (acc_r.sel == slb_pkg::SEL_RX_STAT)) begin
      rx_ie_nxt = HOST_DATA_BUS_I[slb_pkg::IE_BIT];              // [RL6]
    end
    // Follows enable AND flag, so it drops on the read [RL4] [RL5]
    rx_irq_nxt = rx_ie_nxt && rx_valid_nxt;
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_valid_r <= slb_pkg::RX_VALID_RST;
      rx_byte_r  <= slb_pkg::BYTE_RST;
      rx_ie_r    <= slb_pkg::IE_RST;
      rx_irq_r   <= 1'b0;
      ack_req_r  <= 1'b0;
    end else begin
      rx_valid_r <= rx_valid_nxt;
      rx_byte_r  <= rx_byte_nxt;
      rx_ie_r    <= rx_ie_nxt;
      rx_irq_r   <= rx_irq_nxt;
      ack_req_r  <= ack_req_nxt;
    end
  end

  // Transmit side: ready comes back only once sent and acknowledged
  always_comb begin
    tx_ready_nxt = tx_ready_r;
    tx_byte_nxt  = tx_byte_r;
    tx_ie_nxt    = tx_ie_r;
    send_nxt     = 1'b0;
    sent_nxt     = sent_r;
    acked_nxt    = acked_r;
    if (wr_tx_fall) begin
      // A write while busy is accepted; the host must avoid it [RL13]
      tx_ready_nxt = 1'b0;                                      // [RL8]
      sent_nxt     = 1'b0;
      acked_nxt    = 1'b0;
    end
    if (wr_commit && (acc_r.sel == slb_pkg::SEL_TX_DATA)) begin
      tx_byte_nxt = HOST_DATA_BUS_I;        // Data taken at rise [RL22]
      send_nxt    = 1'b1;                   // [RL9]
    end
    if (wr_commit && (acc_r.sel == slb_pkg::SEL_TX_STAT)) begin
      tx_ie_nxt = HOST_DATA_BUS_I[slb_pkg::IE_BIT];              // [RL6]
    end
    if (data_done && !tx_ready_r) begin
      sent_nxt = 1'b1;
    end
    // Stray acks while idle are not counted
    if (rx_evt.ack_vld && !tx_ready_r) begin
      acked_nxt = 1'b1;
    end
    if (!tx_ready_nxt && sent_nxt && acked_nxt) begin
      tx_ready_nxt = 1'b1;                                      // [RL10]
      sent_nxt     = 1'b0;
      acked_nxt    = 1'b0;
    end
    // Drops at the write strobe, rises with ready [RL11] [RL12] [RL18]
    tx_irq_nxt = tx_ie_nxt && tx_ready_nxt;
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_ready_r <= slb_pkg::TX_READY_RST;                      // [RL8]
      tx_byte_r  <= slb_pkg::BYTE_RST;
      tx_ie_r    <= slb_pkg::IE_RST;
      tx_irq_r   <= 1'b0;
      send_r     <= 1'b0;
      sent_r     <= 1'b0;
      acked_r    <= 1'b0;
    end else begin
      tx_ready_r <= tx_ready_nxt;
      tx_byte_r  <= tx_byte_nxt;
      tx_ie_r    <= tx_ie_nxt;
      tx_irq_r   <= tx_irq_nxt;
      send_r     <= send_nxt;
      sent_r     <= sent_nxt;
      acked_r    <= acked_nxt;
    end
  end

  // Serial output; bit time is a fixed clock count [RL20] [RL16] [RL19]
  slb_link_tx u_tx (
    .clk_i       (CLK_I),
    .rst_n_i     (RESETN_I),
    .send_data_i (send_r),
    .data_byte_i (tx_byte_r),
    .send_ack_i  (ack_req_r),                                   // [RL17]
    .serial_o    (SERIAL_OUT_O),
    .data_done_o (data_done)
  );

  // Serial input; reports data packets and acks separately
  slb_link_rx u_rx (
    .clk_i    (CLK_I),
    .rst_n_i  (RESETN_I),
    .serial_i (SERIAL_IN_I),
    .evt_o    (rx_evt)
  );

  // Outputs straight from flops; polling and interrupts both work [RL15]
  assign HOST_DATA_BUS_O    = dout_r;
  assign HOST_DATA_BUS_OE_O = doe_r;
  assign RX_IRQ_OUT_O       = rx_irq_r;
  assign TX_IRQ_OUT_O       = tx_irq_r;

endmodule

// ---- dv/slb_host_port_monitor.sv ----
`timescale 1ns/100ps
module slb_host_port_monitor (
  input wire logic       CLK_I,
  input wire logic       RESETN_I,
  input wire logic       CHIP_SELECT_N_I,
  input wire logic       READ_NOT_WRITE_I,
  input wire logic [1:0] REG_SELECT_I,
  input wire logic [7:0] HOST_DATA_BUS_I,
  input wire logic [7:0] HOST_DATA_BUS_O,
  input wire logic       HOST_DATA_BUS_OE_O,
  input wire logic       SERIAL_IN_I,
  input wire logic       SERIAL_OUT_O,
  input wire logic       RX_IRQ_OUT_O,
  input wire logic       TX_IRQ_OUT_O
);
  logic       cs_q_r;
  logic       cs_q_nxt;
  logic [1:0] kind_r;
  logic [1:0] kind_nxt;
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;

  // Kind of access latched at select fall; run length of high link bits
  always_comb begin
    cs_q_nxt = CHIP_SELECT_N_I;
    kind_nxt = kind_r;
    hi_nxt   = SERIAL_OUT_O ? hi_r + 8'h01 : 8'h00;
    if (cs_q_r && !CHIP_SELECT_N_I) begin
      kind_nxt[1] = (REG_SELECT_I == 2'h1) && !READ_NOT_WRITE_I;
      kind_nxt[0] = (REG_SELECT_I == 2'h0) && READ_NOT_WRITE_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cs_q_r <= 1'b1;
      kind_r <= 2'h0;
      hi_r   <= 8'h00;
    end else begin
      cs_q_r <= cs_q_nxt;
      kind_r <= kind_nxt;
      hi_r   <= hi_nxt;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  chk_rxirq_read_drop: assert property (
    $fell(CHIP_SELECT_N_I) && READ_NOT_WRITE_I && REG_SELECT_I == 2'h0
    |=> !RX_IRQ_OUT_O) else $error("rx irq stayed high after data read");
  chk_txirq_write_drop: assert property (
    $fell(CHIP_SELECT_N_I) && !READ_NOT_WRITE_I && REG_SELECT_I == 2'h1
    |=> !TX_IRQ_OUT_O) else $error("tx irq stayed high after data write");
  chk_read_bus_drive: assert property (
    $fell(CHIP_SELECT_N_I) && READ_NOT_WRITE_I |=> HOST_DATA_BUS_OE_O)
    else $error("bus not driven on read");
  chk_write_bus_quiet: assert property (
    $fell(CHIP_SELECT_N_I) && !READ_NOT_WRITE_I |=> !HOST_DATA_BUS_OE_O)
    else $error("bus driven on write");
  chk_bus_release_after: assert property (
    $rose(CHIP_SELECT_N_I) |=> !HOST_DATA_BUS_OE_O)
    else $error("bus still driven after deselect");
  chk_status_upper_zero: assert property (
    $fell(CHIP_SELECT_N_I) && READ_NOT_WRITE_I && REG_SELECT_I[1]
    |=> HOST_DATA_BUS_O[7:2] == 6'h00)
    else $error("status upper bits not zero");
  chk_link_bit_run: assert property (
    $fell(SERIAL_OUT_O) |-> (hi_r % 20) == 0)
    else $error("link high run not whole bit times");
  chk_ack_start_window: assert property (
    $rose(CHIP_SELECT_N_I) && kind_r[0] |-> ##[16:270] $rose(SERIAL_OUT_O))
    else $error("acknowledge did not start in time");
  chk_data_start_window: assert property (
    $rose(CHIP_SELECT_N_I) && kind_r[1] |-> ##[16:90] $rose(SERIAL_OUT_O))
    else $error("data packet did not start in time");
endmodule

bind slb_host_port slb_host_port_monitor slb_host_port_monitor_i (
  .CLK_I              (CLK_I),
  .RESETN_I           (RESETN_I),
  .CHIP_SELECT_N_I    (CHIP_SELECT_N_I),
  .READ_NOT_WRITE_I   (READ_NOT_WRITE_I),
  .REG_SELECT_I       (REG_SELECT_I),
  .HOST_DATA_BUS_I    (HOST_DATA_BUS_I),
  .HOST_DATA_BUS_O    (HOST_DATA_BUS_O),
  .HOST_DATA_BUS_OE_O (HOST_DATA_BUS_OE_O),
  .SERIAL_IN_I        (SERIAL_IN_I),
  .SERIAL_OUT_O       (SERIAL_OUT_O),
  .RX_IRQ_OUT_O       (RX_IRQ_OUT_O),
  .TX_IRQ_OUT_O       (TX_IRQ_OUT_O)
);

// ---- dv/slb_link_peer.sv ----
`timescale 1ns/100ps
module slb_link_peer (
  input  wire logic       clk_i,
  input  wire logic       line_i,
  input  wire logic       send_i,
  input  wire logic [7:0] byte_i,
  input  wire logic [9:0] ack_dly_i,
  output logic            line_o,
  output logic [7:0]      got_byte_o,
  output logic [7:0]      data_cnt_o,
  output logic [7:0]      ack_cnt_o
);
  localparam int BIT = 20;
  logic       ack_due;
  logic       tx_pend;
  logic [7:0] tx_b;
  logic [7:0] rb;

  // One packet LSB first, then the line rests low for a bit time
  task automatic put(input logic [10:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      line_o <= v[k];
      repeat (BIT) @(posedge clk_i);
    end
    line_o <= 1'b0;
    repeat (BIT) @(posedge clk_i);
  endtask

  // Sender; a due acknowledge goes ahead of queued data
  initial begin
    line_o  = 1'b0;
    ack_due = 1'b0;
    tx_pend = 1'b0;
    forever begin
      @(posedge clk_i);
      if (ack_due) begin
        ack_due = 1'b0;
        repeat (ack_dly_i) @(posedge clk_i);
        put(11'h001, 2);
      end else if (tx_pend) begin
        tx_pend = 1'b0;
        put({1'b0, tx_b, 2'b11}, 11);
      end
    end
  end

  always @(posedge clk_i) begin
    if (send_i) begin
      tx_pend = 1'b1;
      tx_b    = byte_i;
    end
  end

  // Receiver samples bit centres of what the device sends
  initial begin
    data_cnt_o = 8'h00;
    ack_cnt_o  = 8'h00;
    got_byte_o = 8'h00;
    forever begin
      @(posedge clk_i iff line_i === 1'b1);
      repeat (BIT + BIT / 2) @(posedge clk_i);
      if (line_i) begin
        for (int k = 0; k < 8; k++) begin
          repeat (BIT) @(posedge clk_i);
          rb[k] = line_i;
        end
        repeat (BIT) @(posedge clk_i);
        got_byte_o = rb;
        data_cnt_o++;
        ack_due = 1'b1;
      end else begin
        ack_cnt_o++;
      end
    end
  end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cs_n = 1'b1;
  logic       rnw = 1'b1;
  logic [1:0] sel = 2'h0;
  logic [7:0] drv = 8'h00;
  logic       send = 1'b0;
  logic [7:0] sbyte = 8'h00;
  logic [9:0] ack_dly = 10'h000;
  logic [7:0] dout;
  logic       oe;
  logic       ser_o;
  logic       ser_i;
  logic       rx_irq;
  logic       tx_irq;
  logic [7:0] got;
  logic [7:0] dcnt;
  logic [7:0] acnt;
  logic [7:0] q;
  logic [7:0] b;
  int         errors = 0;
  int         checks_done = 0;
  wire  [7:0] bus = oe ? dout : drv;

  always #2.5 clk = ~clk;

  slb_host_port slb_host_port_i (
    .CLK_I(clk), .RESETN_I(rst_n), .CHIP_SELECT_N_I(cs_n),
    .READ_NOT_WRITE_I(rnw), .REG_SELECT_I(sel), .HOST_DATA_BUS_I(bus),
    .HOST_DATA_BUS_O(dout), .HOST_DATA_BUS_OE_O(oe), .SERIAL_IN_I(ser_i),
    .SERIAL_OUT_O(ser_o), .RX_IRQ_OUT_O(rx_irq), .TX_IRQ_OUT_O(tx_irq));

  slb_link_peer slb_link_peer_i (
    .clk_i(clk), .line_i(ser_o), .send_i(send), .byte_i(sbyte),
    .ack_dly_i(ack_dly), .line_o(ser_i), .got_byte_o(got),
    .data_cnt_o(dcnt), .ack_cnt_o(acnt));

  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] stat(input logic f, input logic ie);
    return {6'h00, ie, f};
  endfunction

  // One select cycle; select and direction wander once latched
  task automatic acc(input logic [1:0] s, input logic r, input logic [7:0] w);
    @(posedge clk);
    cs_n <= 1'b0;
    sel  <= s;
    rnw  <= r;
    drv  <= w;
    @(posedge clk);
    sel <= ~s;
    rnw <= ~r;
    repeat (2) @(posedge clk);
    q = bus;
    check("bus drive", {7'h00, oe}, {7'h00, r});
    cs_n <= 1'b1;
    @(posedge clk);
  endtask

  // Bounded wait: 0 rx irq, 1 tx irq, 2 peer data count, 3 peer acks
  task automatic wait_on(input int k, input logic [7:0] n);
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      if ((k == 0 && rx_irq === 1'b1) || (k == 1 && tx_irq === 1'b1) ||
          (k == 2 && dcnt === n) || (k == 3 && acnt === n))
        return;
    end
    errors++;
    $display("ERROR wait %0d expected done seen timeout", k);
    tally_and_finish();
  endtask

  task automatic psend(input logic [7:0] v);
    @(posedge clk);
    send  <= 1'b1;
    sbyte <= v;
    @(posedge clk);
    send <= 1'b0;
  endtask

  initial begin
    void'($urandom(4908));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("rx irq", {7'h00, rx_irq}, 8'h00);
    check("tx irq", {7'h00, tx_irq}, 8'h00);
    acc(2'h2, 1'b1, 8'h00);
    check("rx status", q, stat(1'b0, 1'b0));
    acc(2'h3, 1'b1, 8'h00);
    check("tx status", q, stat(1'b1, 1'b0));
    acc(2'h1, 1'b1, 8'h00); // Contents free on this read
    // Enable bits both ways; flag and upper bits always written zero
    for (int s = 2; s < 4; s++) begin
      acc(s[1:0], 1'b0, 8'h02);
      acc(s[1:0], 1'b1, 8'h00);
      check("status ie", q, stat(s == 3, 1'b1));
      check("tx irq", {7'h00, tx_irq}, {7'h00, s == 3});
      acc(s[1:0], 1'b0, 8'h00);
      acc(s[1:0], 1'b1, 8'h00);
      check("status ie", q, stat(s == 3, 1'b0));
    end
    // Receive boundary and random bytes, serviced on the interrupt
    acc(2'h2, 1'b0, 8'h02);
    for (int n = 1; n <= 3; n++) begin
      b = (n == 1) ? 8'hFF : (n == 2) ? 8'h00 : 8'($urandom);
      psend(b);
      wait_on(0, 8'h00);
      acc(2'h2, 1'b0, 8'h00);
      acc(2'h0, 1'b0, 8'h5A);
      check("rx irq", {7'h00, rx_irq}, 8'h00);
      acc(2'h2, 1'b1, 8'h00);
      check("rx status", q, stat(1'b1, 1'b0));
      acc(2'h2, 1'b0, 8'h02);
      repeat (2) @(posedge clk);
      check("rx irq", {7'h00, rx_irq}, 8'h01);
      acc(2'h0, 1'b1, 8'h00);
      check("rx data", q, b);
      check("rx irq", {7'h00, rx_irq}, 8'h00);
      wait_on(3, 8'(n));
      acc(2'h2, 1'b1, 8'h00);
      check("rx status", q, stat(1'b0, 1'b1));
    end
    // Transmit with prompt and slow acknowledges, reading the flag, serviced on the interrupt
    acc(2'h3, 1'b0, 8'h02);
    for (int n = 1; n <= 4; n++) begin
      b = 8'($urandom);
      ack_dly <= n[0] ? 10'h000 : 10'($urandom_range(100, 300));
      acc(2'h3, 1'b1, 8'h00);
      check("tx status", q, stat(1'b1, 1'b1));
      acc(2'h1, 1'b0, b);
      check("tx irq", {7'h00, tx_irq}, 8'h00);
      acc(2'h3, 1'b1, 8'h00);
      check("tx status", q, stat(1'b0, 1'b1));
      wait_on(2, 8'(n));
      check("link byte", got, b);
      acc(2'h3, 1'b1, 8'h00);
      check("tx status", q, stat(1'b0, 1'b1));
      wait_on(1, 8'h00);
    end
    // Write then read at once, so data and acknowledge share the link
    psend(8'hA5);
    wait_on(0, 8'h00);
    acc(2'h1, 1'b0, 8'h3C);
    acc(2'h0, 1'b1, 8'h00);
    check("rx data", q, 8'hA5);
    wait_on(3, 8'h04);
    wait_on(2, 8'h05);
    check("link byte", got, 8'h3C);
    wait_on(1, 8'h00);
    // Mid-run reset with a byte pending and a write just taken
    psend(8'h77);
    wait_on(0, 8'h00);
    acc(2'h1, 1'b0, 8'h11);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("rx irq", {7'h00, rx_irq}, 8'h00);
    acc(2'h2, 1'b1, 8'h00);
    check("rx status", q, stat(1'b0, 1'b0));
    acc(2'h3, 1'b1, 8'h00);
    check("tx status", q, stat(1'b1, 1'b0));
    tally_and_finish();
  end
endmodule
